// File: design/ubc_regs.vh
// ubc_regs.vh: register map, field positions and divider constants
//
// Function
// - prescaler code 01 divides by 4, 10 by 3, 11 by 5
// - rate codes 0000-1011 pick baud generator, 1101 reload timer, 1111 external
// - parity sense 0 means even parity, 1 means odd, when parity is on
// - ninth bit reads received bit 8 and supplies transmitted bit 8
// - data length follows mode and parity: 6/7, 7/8, 8+1, 8/9
// - transmitter sends one or two stop bits, receiver expects one
// - a mode outside the listed modes leaves the port idle
// - every frame carries start and stop bits, synchronous too
// - synchronous upper rate bits 010, 011, 100 divide by 2, 4, 8
// - asynchronous 000/010/011/100 divide by 8 times 1/2/4/8, times 12 or 13
// - asynchronous 001 and 101 need low rate bit 1, 101 divides by 8 more
// - asynchronous rate is synchronous rate over 8x13, 8x12 or 8
// - synchronous rate is prescaled clock over two to the (m minus one)
// - serial clock pin is external input when direction in, output off, code 1111
// - parity is generated and checked only while parity enable is set
`ifndef UBC_REGS_VH
`define UBC_REGS_VH

// word addresses on the register bus
`define UBC_ADDR_RATE    2'h0
`define UBC_ADDR_MODE    2'h1
`define UBC_ADDR_STAT    2'h2

// rate_and_ninth_bit_control fields
`define UBC_RATE_PS_HI   7
`define UBC_RATE_RC_MSB  6
`define UBC_RATE_RC_LSB  3
`define UBC_RATE_PS_LO   2
`define UBC_RATE_ODD     1
`define UBC_RATE_BIT8    0
`define UBC_RATE_RST     8'h00

// serial_mode_control fields
`define UBC_MODE_MSB     1
`define UBC_MODE_LSB     0
`define UBC_MODE_PEN     2
`define UBC_MODE_STOP2   3
`define UBC_MODE_ASYNC   4
`define UBC_MODE_SERIAL_CLOCK_OUT_ENABLE    5
`define UBC_MODE_RST     8'h00

// prescaler divisors
`define UBC_PS_DIV_01    3'h4
`define UBC_PS_DIV_10    3'h3
`define UBC_PS_DIV_11    3'h5

// rate code points
`define UBC_RC_DED_MAX   4'hb
`define UBC_RC_RELOAD    4'hd
`define UBC_RC_EXT       4'hf
`define UBC_ASY_K12      4'hc
`define UBC_ASY_K13      4'hd
`define UBC_ASY_DIV_001  7'h01
`define UBC_ASY_DIV_101  7'h08
`define UBC_OS_PER_BIT   4'h8

// frame data lengths
`define UBC_LEN_M0_PAR   4'h6
`define UBC_LEN_M0_NOP   4'h7
`define UBC_LEN_M1_PAR   4'h7
`define UBC_LEN_M1_NOP   4'h8
`define UBC_LEN_M2       4'h9
`define UBC_LEN_M3_PAR   4'h8
`define UBC_LEN_M3_NOP   4'h9
`define UBC_STOP_ONE     2'h1
`define UBC_STOP_TWO     2'h2

`endif

// File: design/ubc_tick_div.v
// ubc_tick_div.v: enable-driven modulo counter producing a tick
`timescale 1ns/1ns
module ubc_tick_div #(
  parameter W = 7
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire         ce,
  input  wire         en,
  input  wire         clr,
  input  wire [W-1:0] div,
  output wire         tick,
  output wire [W-1:0] cnt
);
  reg  [W-1:0] cnt_reg;
  wire         last;

  // a divisor of one ticks on every enable
  assign last = (cnt_reg == (div - {{(W-1){1'b0}}, 1'b1}));
  assign tick = en & last & ~clr;
  assign cnt  = cnt_reg;

  // counts enables; clear restarts the phase after a setting change
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_reg <= {W{1'b0}};
    else if (ce)
    begin
      if (clr)
        cnt_reg <= {W{1'b0}};
      else if (en)
        cnt_reg <= last ? {W{1'b0}} : cnt_reg + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// File: design/ubc_frame_fmt.v
// ubc_frame_fmt.v: decode of operating mode into frame format
`timescale 1ns/1ns
`include "ubc_regs.vh"
module ubc_frame_fmt (
  input  wire [1:0] mode,
  input  wire       parity_enable,
  output reg  [3:0] data_len,
  output reg        mode_ok,
  output wire       parity_use,
  output wire       nine_bit
);
  // mode 2 with parity is not a listed mode
  always @*
  begin
    mode_ok = 1'b1;
    case (mode)
      2'h0: data_len = parity_enable ? `UBC_LEN_M0_PAR : `UBC_LEN_M0_NOP;
      2'h1: data_len = parity_enable ? `UBC_LEN_M1_PAR : `UBC_LEN_M1_NOP;
      2'h2:
      begin
        data_len = `UBC_LEN_M2;
        mode_ok  = ~parity_enable;
      end
      default: data_len = parity_enable ? `UBC_LEN_M3_PAR : `UBC_LEN_M3_NOP;
    endcase
  end

  // parity only where enabled and the mode carries it
  assign parity_use = parity_enable & mode_ok;
  // the ninth bit means something only in 9-bit modes without parity
  assign nine_bit   = ~parity_enable & mode[1];
endmodule

// File: design/ubc_baud_cfg.v
// ubc_baud_cfg.v: serial port rate generator and frame configuration
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "ubc_regs.vh"
module ubc_baud_cfg (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        ce,
  input  wire [1:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        tx_data_empty_flag,
  input  wire        reload_tick,
  input  wire        sclk_pin_in,
  input  wire        sclk_port_dir_in,
  input  wire        rx_load,
  input  wire        rx_bit8,
  output wire        bit_tick,
  output wire        sample_tick,
  output wire        port_active,
  output wire        async_mode,
  output wire [3:0]  data_len,
  output wire        parity_en,
  output wire        parity_odd,
  output wire        tx_bit8,
  output wire [1:0]  tx_stop_bits,
  output wire [1:0]  rx_stop_bits,
  output wire        frame_start_stop,
  output wire        sclk_out,
  output wire        sclk_oe
);
  // clock source codes for the status register
  localparam SRC_NONE = 2'h0;
  localparam SRC_DED  = 2'h1;
  localparam SRC_RLD  = 2'h2;
  localparam SRC_EXT  = 2'h3;

  reg  [7:0]  rate_reg;
  reg  [7:0]  mode_reg;
  reg         tx_bit8_reg;
  reg         rx_bit8_reg;
  reg         ack_reg;
  reg  [31:0] rdata_reg;
  reg         ext_s1_reg;
  reg         ext_s2_reg;
  reg         ext_s3_reg;
  reg         bit_tick_reg;
  reg         sample_tick_reg;
  reg         active_reg;
  reg         async_reg;
  reg  [3:0]  len_reg;
  reg         par_en_reg;
  reg         par_odd_reg;
  reg  [1:0]  tx_stop_reg;
  reg         sclk_reg;
  reg         sclk_oe_reg;
  reg  [2:0]  ps_div;
  reg  [6:0]  rate_div;
  reg         rate_ok;
  reg  [1:0]  src_sel;
  reg  [31:0] rd_mux;

  wire        req;
  wire        wr_en;
  wire        cfg_wr;
  wire [1:0]  ps_code;
  wire [3:0]  rc;
  wire [2:0]  rc_hi;
  wire        rc_lo;
  wire        is_async;
  wire        serial_clock_out_enable;
  wire        dedicated;
  wire        ext_ok;
  wire        ext_rise;
  wire [3:0]  fmt_len;
  wire        mode_ok;
  wire        parity_use;
  wire        nine_bit;
  wire        clk_run;
  wire        div_clr;
  wire        pre_tick;
  wire        rate_tick;
  wire [6:0]  rate_cnt;
  wire        src_tick;
  wire        os_tick;
  wire [3:0]  asy_k;

  // bus handshake: one wait cycle; a frozen clock enable stretches it,
  // so a write is never acknowledged in a cycle that cannot commit it
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~(ack_reg & ce);
  assign avs_readdata    = rdata_reg;
  assign wr_en           = avs_write & ack_reg & ce & avs_byteenable[0];
  assign cfg_wr          = wr_en & (avs_address != `UBC_ADDR_STAT);

  // field views
  assign ps_code  = {rate_reg[`UBC_RATE_PS_HI], rate_reg[`UBC_RATE_PS_LO]};
  assign rc       = rate_reg[`UBC_RATE_RC_MSB:`UBC_RATE_RC_LSB];
  assign rc_hi    = rc[3:1];
  assign rc_lo    = rc[0];
  assign is_async = mode_reg[`UBC_MODE_ASYNC];
  assign serial_clock_out_enable     = mode_reg[`UBC_MODE_SERIAL_CLOCK_OUT_ENABLE];
  assign asy_k    = rc_lo ? `UBC_ASY_K13 : `UBC_ASY_K12;

  ubc_frame_fmt u_fmt (
    .mode       (mode_reg[`UBC_MODE_MSB:`UBC_MODE_LSB]),
    .parity_enable        (mode_reg[`UBC_MODE_PEN]),
    .data_len   (fmt_len),
    .mode_ok    (mode_ok),
    .parity_use (parity_use),
    .nine_bit   (nine_bit)
  );

  // prescaler divisor; code 00 leaves it stopped
  always @*
  begin
    case (ps_code)
      2'h1:    ps_div = `UBC_PS_DIV_01;
      2'h2:    ps_div = `UBC_PS_DIV_10;
      2'h3:    ps_div = `UBC_PS_DIV_11;
      default: ps_div = 3'h0;
    endcase
  end

  // dedicated generator ratio in prescaled ticks per serial clock;
  // in async the serial clock is eight times the bit rate
  always @*
  begin
    rate_div = 7'h01;
    rate_ok  = 1'b0;
    if (!is_async)
    begin
      case (rc_hi)
        3'h2:
        begin
          rate_div = 7'h02;
          rate_ok  = 1'b1;
        end
        3'h3:
        begin
          rate_div = 7'h04;
          rate_ok  = 1'b1;
        end
        3'h4:
        begin
          rate_div = 7'h08;
          rate_ok  = 1'b1;
        end
        default: rate_ok = 1'b0;
      endcase
    end
    else
    begin
      case (rc_hi)
        3'h0:
        begin
          rate_div = {3'h0, asy_k};
          rate_ok  = 1'b1;
        end
        3'h2:
        begin
          rate_div = {2'h0, asy_k, 1'b0};
          rate_ok  = 1'b1;
        end
        3'h3:
        begin
          rate_div = {1'h0, asy_k, 2'h0};
          rate_ok  = 1'b1;
        end
        3'h4:
        begin
          rate_div = {asy_k[3:0], 3'h0};
          rate_ok  = 1'b1;
        end
        3'h1:
        begin
          rate_div = `UBC_ASY_DIV_001;
          rate_ok  = rc_lo;
        end
        3'h5:
        begin
          rate_div = `UBC_ASY_DIV_101;
          rate_ok  = rc_lo;
        end
        default: rate_ok = 1'b0;
      endcase
    end
  end

  // external clock only while the pin is an input and not driven
  assign ext_ok    = sclk_port_dir_in & ~serial_clock_out_enable;
  assign dedicated = (rc <= `UBC_RC_DED_MAX);

  // clock source selection; codes 1100 and 1110 select nothing
  always @*
  begin
    if (dedicated)
      src_sel = rate_ok ? SRC_DED : SRC_NONE;
    else if (rc == `UBC_RC_RELOAD)
      src_sel = SRC_RLD;
    else if ((rc == `UBC_RC_EXT) && ext_ok)
      src_sel = SRC_EXT;
    else
      src_sel = SRC_NONE;
  end

  // an invalid mode or a prohibited setting stops every divider
  assign clk_run = mode_ok & (ps_div != 3'h0) & (src_sel != SRC_NONE);
  // a setting write restarts the phase; mid-frame changes are not guarded
  assign div_clr = cfg_wr | ~clk_run;

  ubc_tick_div #(.W(3)) u_pre (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .en    (clk_run),
    .clr   (div_clr),
    .div   (ps_div),
    .tick  (pre_tick),
    .cnt   ()
  );

  ubc_tick_div #(.W(7)) u_rate (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .en    (pre_tick & (src_sel == SRC_DED)),
    .clr   (div_clr),
    .div   (rate_div),
    .tick  (rate_tick),
    .cnt   (rate_cnt)
  );

  // serial clock from the chosen source; a stopped port passes no
  // reload or external tick either
  assign src_tick = clk_run & ((src_sel == SRC_DED) ? rate_tick :
                               (src_sel == SRC_RLD) ? reload_tick :
                               (src_sel == SRC_EXT) ? ext_rise : 1'b0);

  // async bit rate is the serial clock over eight
  ubc_tick_div #(.W(4)) u_os (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .en    (src_tick & is_async),
    .clr   (div_clr),
    .div   (`UBC_OS_PER_BIT),
    .tick  (os_tick),
    .cnt   ()
  );

  // the external pin crosses in through two flops; edge seen after them
  assign ext_rise = ext_s2_reg & ~ext_s3_reg;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // the pin idles high; resetting low would fake a rising edge
      ext_s1_reg <= 1'b1;
      ext_s2_reg <= 1'b1;
      ext_s3_reg <= 1'b1;
    end
    else if (ce)
    begin
      ext_s1_reg <= sclk_pin_in;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  // bus slave: ack one cycle after the request, read data captured alongside
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else if (ce)
    begin
      ack_reg <= req & ~ack_reg;
      if (avs_read & ~ack_reg)
        rdata_reg <= rd_mux;
    end
  end

  // read mux; unmapped words read zero
  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `UBC_ADDR_RATE:
        rd_mux[7:0] = {rate_reg[7:1], rx_bit8_reg};
      `UBC_ADDR_MODE:
        rd_mux[7:0] = mode_reg;
      `UBC_ADDR_STAT:
        rd_mux[12:0] = {tx_stop_reg == `UBC_STOP_TWO, len_reg, 3'h0,
                        src_sel, tx_data_empty_flag, clk_run, active_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // software registers; the ninth bit written goes to the transmitter
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rate_reg    <= `UBC_RATE_RST;
      mode_reg    <= `UBC_MODE_RST;
      tx_bit8_reg <= 1'b0;
    end
    else if (wr_en)
    begin
      if (avs_address == `UBC_ADDR_RATE)
      begin
        rate_reg    <= avs_writedata[7:0];
        // written on every rate register write, whether or not the transmit buffer is empty
        tx_bit8_reg <= avs_writedata[`UBC_RATE_BIT8];
      end
      else if (avs_address == `UBC_ADDR_MODE)
        mode_reg <= {2'h0, avs_writedata[5:0]};
    end
  end

  // received bit 8 is caught when the receiver loads a word while nine_bit is set
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rx_bit8_reg <= 1'b0;
    else if (ce && rx_load && nine_bit)
      rx_bit8_reg <= rx_bit8;
  end

  // registered configuration and tick outputs
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bit_tick_reg    <= 1'b0;
      sample_tick_reg <= 1'b0;
      active_reg      <= 1'b0;
      async_reg       <= 1'b0;
      len_reg         <= 4'h0;
      par_en_reg      <= 1'b0;
      par_odd_reg     <= 1'b0;
      tx_stop_reg     <= `UBC_STOP_ONE;
      sclk_reg        <= 1'b1;
      sclk_oe_reg     <= 1'b0;
    end
    else if (ce)
    begin
      bit_tick_reg    <= is_async ? os_tick : src_tick;
      sample_tick_reg <= src_tick;
      active_reg      <= mode_ok;
      async_reg       <= is_async;
      len_reg         <= fmt_len;
      par_en_reg      <= parity_use;
      par_odd_reg     <= rate_reg[`UBC_RATE_ODD];
      tx_stop_reg     <= mode_reg[`UBC_MODE_STOP2] ? `UBC_STOP_TWO
                                                   : `UBC_STOP_ONE;
      // square clock from the generator, a low pulse per reload tick
      sclk_reg        <= (src_sel == SRC_DED) ?
                         (rate_cnt >= {1'b0, rate_div[6:1]}) : ~src_tick;
      // clock drives out only in sync with an internal source
      sclk_oe_reg     <= serial_clock_out_enable & ~is_async & clk_run &
                         (src_sel != SRC_EXT);
    end
  end

  assign bit_tick         = bit_tick_reg;
  assign sample_tick      = sample_tick_reg;
  assign port_active      = active_reg;
  assign async_mode       = async_reg;
  assign data_len         = len_reg;
  assign parity_en        = par_en_reg;
  assign parity_odd       = par_odd_reg;
  assign tx_bit8          = tx_bit8_reg;
  assign tx_stop_bits     = tx_stop_reg;
  // the receiver checks one stop bit whatever the setting
  assign rx_stop_bits     = `UBC_STOP_ONE;
  // start and stop framing in both transfer methods
  assign frame_start_stop = active_reg;
  assign sclk_out         = sclk_reg;
  assign sclk_oe          = sclk_oe_reg;
endmodule

// File: dv/ubc_baud_cfg_asserts.sv
// checker: port-level properties of the rate and frame config block
`timescale 1ns/1ns
module ubc_cfg_asserts (
  input wire        clk,
  input wire        rst_b,
  input wire        ce,
  input wire [1:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire        avs_waitrequest,
  input wire        bit_tick,
  input wire        sample_tick,
  input wire        port_active,
  input wire        async_mode,
  input wire [3:0]  data_len,
  input wire        parity_en,
  input wire        tx_bit8,
  input wire [1:0]  tx_stop_bits,
  input wire [1:0]  rx_stop_bits,
  input wire        frame_start_stop
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  reg  [3:0] os_cnt_reg;
  reg        os_ok_reg;
  wire       wr_acc = avs_write && !avs_waitrequest;
  // sample ticks per bit; a write restarts phases so the count is voided
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      os_cnt_reg <= 4'h0;
      os_ok_reg  <= 1'b0;
    end
    else if (wr_acc)
    begin
      os_cnt_reg <= 4'h0;
      os_ok_reg  <= 1'b0;
    end
    else if (bit_tick)
    begin
      os_cnt_reg <= 4'h0;
      os_ok_reg  <= 1'b1;
    end
    else if (sample_tick)
      os_cnt_reg <= os_cnt_reg + 4'h1;
  AST_RX_STOP_ONE: assert property (
    rx_stop_bits == 2'h1) else $error("rx stop count not one");
  AST_TX_STOP_LEGAL: assert property (
    tx_stop_bits == 2'h1 || tx_stop_bits == 2'h2)
    else $error("tx stop count illegal");
  AST_FRAME_BITS: assert property (
    frame_start_stop == port_active) else $error("framing flag off");
  AST_WAIT_ONE: assert property (
    (avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
    else $error("more than one wait cycle");
  AST_WAIT_IDLE: assert property (
    !(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait without request");
  AST_IDLE_NO_TICK: assert property (
    !port_active && $past(!port_active) |-> !bit_tick && !sample_tick)
    else $error("tick while port idle");
  AST_LEN_PARITY: assert property (
    data_len == 4'h9 |-> !parity_en) else $error("nine bits with parity");
  AST_OS_EIGHT: assert property (
    bit_tick && async_mode && os_ok_reg |-> os_cnt_reg + sample_tick == 4'h8)
    else $error("async bit not eight samples");
  AST_TX_BIT8: assert property (
    wr_acc && ce && avs_address == 2'h0 && avs_byteenable[0]
    |=> ##1 tx_bit8 == $past(avs_writedata[0], 2))
    else $error("ninth bit not taken");
  cover property (bit_tick && async_mode && os_ok_reg);
  cover property (wr_acc && avs_address == 2'h0);
  cover property ($fell(port_active));
endmodule

// File: dv/ubc_line_model.sv
// far-side model: reload ticks, external serial clock, received words
`timescale 1ns/1ns
module ubc_line_model #(
  parameter RL_PER   = 40,
  parameter EXT_HALF = 6
) (
  input  wire clk,
  input  wire rst_b,
  input  wire ext_run,
  input  wire rx_req,
  input  wire rx_val,
  output reg  reload_tick,
  output reg  sclk_pin_in,
  output reg  rx_load,
  output reg  rx_bit8
);
  integer rl_cnt;
  integer ex_cnt;
  // exact-rate sources; the serial clock stands high while ext_run is low
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      rl_cnt <= 0;
      ex_cnt <= 0;
      reload_tick <= 1'b0;
      sclk_pin_in <= 1'b1;
      rx_load <= 1'b0;
      rx_bit8 <= 1'b0;
    end
    else
    begin
      rl_cnt <= (rl_cnt == RL_PER - 1) ? 0 : rl_cnt + 1;
      reload_tick <= (rl_cnt == RL_PER - 1);
      ex_cnt <= (!ext_run || ex_cnt == EXT_HALF - 1) ? 0 : ex_cnt + 1;
      if (!ext_run)
        sclk_pin_in <= 1'b1;
      else if (ex_cnt == EXT_HALF - 1)
        sclk_pin_in <= ~sclk_pin_in;
      rx_load <= rx_req;
      rx_bit8 <= rx_req ? rx_val : ~rx_bit8; // junk outside the strobe
    end
endmodule

// File: dv/ubc_baud_cfg_tb_top.sv
// testbench: bus, rate, frame format and clock source checks
`timescale 1ns/1ns
module ubc_baud_cfg_tb_top;
  logic        clk, rst_b, ce, avs_read, avs_write, tx_data_empty_flag;
  logic [1:0]  avs_address, tx_stop_bits, rx_stop_bits;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [3:0]  avs_byteenable, data_len;
  logic        avs_waitrequest, reload_tick, sclk_pin_in, sclk_port_dir_in;
  logic        rx_load, rx_bit8, bit_tick, sample_tick, port_active;
  logic        async_mode, parity_en, parity_odd, tx_bit8, frame_start_stop;
  logic        sclk_out, sclk_oe, ext_run, rx_req, rx_val, asy;
  logic [7:0]  r, m;
  integer      n_fail, samples_checked, cyc, seed, i, p, e;
  logic [3:0]  len_tab [8] = '{4'h7, 4'h8, 4'h9, 4'h9, 4'h6, 4'h7, 4'h0, 4'h8};
  ubc_baud_cfg dut (.clk(clk), .rst_b(rst_b), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_data_empty_flag(tx_data_empty_flag), .reload_tick(reload_tick),
    .sclk_pin_in(sclk_pin_in), .sclk_port_dir_in(sclk_port_dir_in),
    .rx_load(rx_load), .rx_bit8(rx_bit8), .bit_tick(bit_tick),
    .sample_tick(sample_tick), .port_active(port_active),
    .async_mode(async_mode), .data_len(data_len), .parity_en(parity_en),
    .parity_odd(parity_odd), .tx_bit8(tx_bit8), .tx_stop_bits(tx_stop_bits),
    .rx_stop_bits(rx_stop_bits), .frame_start_stop(frame_start_stop),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe));
  ubc_line_model #(.RL_PER(40), .EXT_HALF(6)) line (.clk(clk),
    .rst_b(rst_b), .ext_run(ext_run), .rx_req(rx_req), .rx_val(rx_val),
    .reload_tick(reload_tick), .sclk_pin_in(sclk_pin_in),
    .rx_load(rx_load), .rx_bit8(rx_bit8));
  always #25 clk = ~clk;
  task tally_and_finish;
  begin
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
  begin
    samples_checked = samples_checked + 1;
    if (got !== ex)
    begin
      n_fail = n_fail + 1;
      $display("MISMATCH %s exp %0h got %0h", nm, ex, got);
    end
  end
  endtask
  // one bus access; held until waitrequest is seen low at a rising edge,
  // read data taken and the request dropped at that same edge
  task bus(input logic wr, input logic [1:0] a, input logic [7:0] wd,
           input logic [3:0] be);
  begin
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, wd};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  end
  endtask
  // cycles between two bit ticks, zero if fewer than two seen
  task meas(input integer lim, output integer pr);
    integer k, n;
  begin
    pr = 0;
    k = 0;
    n = 0;
    while (n < 2 && k < lim)
    begin
      @(negedge clk);
      k = k + 1;
      if (n == 1)
        pr = pr + 1;
      if (bit_tick === 1'b1)
        n = n + 1;
    end
    if (n < 2)
      pr = 0;
  end
  endtask
  // expected bit period in clk cycles, zero for a refused setting
  function integer exp_per(input logic [7:0] rt, input logic as_m);
    integer pp, dd, mm;
  begin
    pp = ({rt[7], rt[2]} == 2'h1) ? 4 : ({rt[7], rt[2]} == 2'h2) ? 3 :
         ({rt[7], rt[2]} == 2'h3) ? 5 : 0;
    mm = rt[6:4];
    if (!as_m)
      dd = (mm == 2) ? 2 : (mm == 3) ? 4 : (mm == 4) ? 8 : 0;
    else if (mm == 1 || mm == 5)
      dd = rt[3] ? ((mm == 1) ? 8 : 64) : 0;
    else
      dd = ((mm == 0) ? 8 : (mm == 2) ? 16 : (mm == 3) ? 32 :
            (mm == 4) ? 64 : 0) * (rt[3] ? 13 : 12);
    exp_per = pp * dd;
  end
  endfunction
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 90000)
    begin
      n_fail = n_fail + 1;
      tally_and_finish;
    end
  end
  initial
  begin
    {clk, rst_b, avs_read, avs_write, rx_req, rx_val, ext_run} = 7'h0;
    {avs_address, avs_writedata, avs_byteenable} = 38'h0;
    {ce, tx_data_empty_flag, sclk_port_dir_in} = 3'h4;
    {n_fail, samples_checked, cyc, m} = 0;
    seed = 32'h9f09203a;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, 2'h0, 8'h00, 4'hf);
    chk("rate reset", 32'h0, d);
    bus(1'b1, 2'h3, 8'hff, 4'hf);
    bus(1'b0, 2'h3, 8'h00, 4'hf);
    chk("unmapped", 32'h0, d);
    $display("test reset done");
    tx_data_empty_flag <= 1'b1;
    for (i = 0; i < 8; i++)
    begin
      r = $random(seed);
      bus(1'b1, 2'h0, r, (i == 7) ? 4'he : 4'hf);
      m = (i == 7) ? m : r;
      bus(1'b0, 2'h0, 8'h00, 4'hf);
      chk("rate read", m[7:1], d[7:1]);
      repeat (2) @(negedge clk);
      chk("tx bit8", m[0], tx_bit8);
      chk("odd sense", m[1], parity_odd);
    end
    $display("test rate register done");
    for (i = 0; i < 16; i++)
    begin
      m = 8'(i);
      bus(1'b1, 2'h1, m, 4'hf);
      repeat (2) @(negedge clk);
      e = (m[2:0] != 3'h6);
      chk("active", e, port_active);
      bus(1'b0, 2'h2, 8'h00, 4'hf);
      if (e)
      begin
        chk("length", len_tab[m[2:0]], data_len);
        chk("status length", len_tab[m[2:0]], d[11:8]);
        chk("parity on", m[2], parity_en);
        chk("tx stop", m[3] ? 32'h2 : 32'h1, tx_stop_bits);
      end
    end
    $display("test frame format done");
    for (i = 0; i < 26; i++)
    begin
      r = $random(seed);
      asy = i[0];
      r[6:3] = 4'(i / 2);
      // the last pair keeps code 1100 so the sync pass meets it too
      r[3] = r[3] | (!asy && i < 24);
      if (i == 1)
        {r[7], r[2]} = 2'h0;
      e = exp_per(r, asy);
      bus(1'b1, 2'h1, {2'h0, !asy, asy, 4'h1}, 4'hf);
      bus(1'b1, 2'h0, r, 4'hf);
      meas(e ? 2 * e + 50 : 300, p);
      chk("period", e, p);
      chk("async", asy, async_mode);
      // a sync generator clock is low for half of each bit period
      if (!asy && e)
      begin
        p = 0;
        repeat (e)
        begin
          @(negedge clk);
          p = p + !sclk_out;
        end
        chk("sclk low", e / 2, p);
      end
      bus(1'b0, 2'h2, 8'h00, 4'hf);
      chk("clock running", e != 0, d[1]);
    end
    $display("test generator done");
    bus(1'b1, 2'h1, 8'h21, 4'hf);
    bus(1'b1, 2'h0, 8'h6c, 4'hf);
    meas(200, p);
    chk("reload sync", 32'd40, p);
    chk("clock out", 1'b1, sclk_oe);
    bus(1'b1, 2'h1, 8'h11, 4'hf);
    meas(800, p);
    chk("reload async", 32'd320, p);
    chk("clock out", 1'b0, sclk_oe);
    bus(1'b1, 2'h1, 8'h01, 4'hf);
    bus(1'b1, 2'h0, 8'h7c, 4'hf);
    sclk_port_dir_in <= 1'b1;
    ext_run <= 1'b1;
    meas(200, p);
    chk("external", 32'd12, p);
    chk("clock out", 1'b0, sclk_oe);
    sclk_port_dir_in <= 1'b0;
    meas(300, p);
    chk("external off", 32'd0, p);
    ext_run <= 1'b0;
    $display("test clock sources done");
    bus(1'b1, 2'h1, 8'h03, 4'hf);
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk);
      rx_val <= i[0];
      rx_req <= 1'b1;
      @(posedge clk);
      rx_req <= 1'b0;
      tx_data_empty_flag <= i[1];
      bus(1'b0, 2'h0, 8'h00, 4'hf);
      chk("rx bit8", i[0], d[0]);
      bus(1'b0, 2'h2, 8'h00, 4'hf);
      chk("tx empty", i[1], d[2]);
    end
    $display("test received bit done");
    tally_and_finish;
  end
endmodule
bind ubc_baud_cfg ubc_cfg_asserts u_chk (.clk(clk), .rst_b(rst_b),
  .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .bit_tick(bit_tick), .sample_tick(sample_tick),
  .port_active(port_active), .async_mode(async_mode),
  .data_len(data_len), .parity_en(parity_en), .tx_bit8(tx_bit8),
  .tx_stop_bits(tx_stop_bits), .rx_stop_bits(rx_stop_bits),
  .frame_start_stop(frame_start_stop));
